// file: core/pdm_input_path.v
`timescale 1ns/100ps
`default_nettype none
`include "pdm_mic_map.vh"

module pdm_input_path #(
    parameter NPATH = 6,                // stereo input paths
    parameter NMODE = 3                 // paths with a mode select
) (
    input wire ref_clk,                 // core clock, 100 MHz
    input wire resetn,                  // async reset, active low
    input wire [15:0] reg_addr,         // register word address
    input wire [15:0] reg_wdata,        // register write data
    input wire reg_wr_en,               // write strobe
    input wire reg_rd_en,               // read strobe
    output reg [15:0] reg_rdata_q,      // read data, one cycle later
    input wire core_clock_on,           // system clock running
    input wire [7:0] clock_capacity,    // channels the clock can serve
    input wire clock_family_flag,       // 1: 5.6448 MHz family
    input wire [NMODE-1:0] path_input_type_select, // 1: digital mic
    input wire [NPATH*3-1:0] pdm_clock_rate_select, // rate per path
    input wire [NPATH-1:0] noise_cancel_source,    // path feeds anc
    input wire [11:0] mute_set,         // pulse: mute channel
    input wire [11:0] mute_clear,       // pulse: unmute channel
    input wire [NPATH-1:0] pdm_data_pin,           // data pads
    output wire [NPATH-1:0] pdm_clock_pin,         // clock pads
    output wire [NPATH-1:0] pdm_data_pulldown_en,  // pad pull-downs
    output reg [NPATH-1:0] pcm_left_q,  // left bit, muted to 0
    output reg [NPATH-1:0] pcm_right_q, // right bit, muted to 0
    output reg [NPATH-1:0] pcm_valid_q, // pulse: bit pair ready
    output reg [11:0] mute_q,           // per-channel mute state
    output reg underclock_err_q,        // pulse: enable refused
    output reg [1:0] sample_rate_limit_q // max input sample rate code
);

    reg [15:0] enables_q;
    reg [11:0] active_q;
    reg [11:0] active_d;
    reg refused_d;
    reg [8:0] used;
    reg [1:0] limit_d;
    integer i;
    integer j;
    integer m;
    localparam NCHAN = 2 * NPATH;

    wire [NPATH-1:0] path_dig;
    wire [NPATH-1:0] path_run;
    wire [NPATH*3-1:0] eff_rate;
    wire [NPATH-1:0] clk_run;
    wire [NPATH-1:0] ph_end;
    wire [NPATH-1:0] ph_high;
    wire [NPATH-1:0] cap_left;
    wire [NPATH-1:0] cap_right;
    wire [NPATH-1:0] cap_valid;
    wire [NPATH-1:0] left_pass;
    wire [NPATH-1:0] right_pass;
    wire en_wr;
    wire [15:0] status_word;

    // accumulator step for one rate code; zero marks a reserved code
    // integer steps make each half period jitter by one core cycle
    function [23:0] rate_inc;
        input [2:0] code;
        input frac;
        reg [63:0] v;
        begin
            v = 64'd0;
            case (code)
                `PDM_RATE_384K: begin
                    v = frac ? `PDM_ACC_INC_FRAC(`PDM_F384K_HZ)
                             : `PDM_ACC_INC(`PDM_F384K_HZ);
                end
                `PDM_RATE_768K: begin
                    v = frac ? `PDM_ACC_INC_FRAC(`PDM_F768K_HZ)
                             : `PDM_ACC_INC(`PDM_F768K_HZ);
                end
                `PDM_RATE_1536K: begin
                    v = frac ? `PDM_ACC_INC_FRAC(`PDM_F1536K_HZ)
                             : `PDM_ACC_INC(`PDM_F1536K_HZ);
                end
                `PDM_RATE_3072K: begin
                    v = frac ? `PDM_ACC_INC_FRAC(`PDM_F3072K_HZ)
                             : `PDM_ACC_INC(`PDM_F3072K_HZ);
                end
                `PDM_RATE_6144K: begin
                    v = frac ? `PDM_ACC_INC_FRAC(`PDM_F6144K_HZ)
                             : `PDM_ACC_INC(`PDM_F6144K_HZ);
                end
                default: begin
                    v = 64'd0;
                end
            endcase
            rate_inc = v[23:0];
        end
    endfunction

    // sample rate ceiling implied by one effective rate code
    function [1:0] rate_limit_code;
        input [2:0] code;
        begin
            case (code)
                `PDM_RATE_384K: begin
                    rate_limit_code = `RATE_LIMIT_48K;
                end
                `PDM_RATE_768K: begin
                    rate_limit_code = `RATE_LIMIT_96K;
                end
                default: begin
                    // faster clocks allow the full rate
                    rate_limit_code = `RATE_LIMIT_192K;
                end
            endcase
        end
    endfunction

    // one decode of the enable write, shared by admission and storage
    assign en_wr = reg_wr_en && (reg_addr == `IPE_ENABLES_ADDR);

    // status word: admitted channels, upper bits zero
    assign status_word = {4'h0, active_q};

    assign pdm_data_pulldown_en = {NPATH{1'b1}};

    // admit new enables only within capacity
    always @* begin
        active_d = active_q;
        refused_d = 1'b0;
        used = 9'h000;
        if (en_wr) begin
            // disables always take effect; kept channels count first
            active_d = active_q & reg_wdata[`IPE_CHAN_MSB:`IPE_CHAN_LSB];
            for (i = 0; i < NCHAN; i = i + 1) begin
                used = used + {8'h00, active_d[i]};
            end
            // new requests granted lowest bit first, so refusals repeat
            for (i = 0; i < NCHAN; i = i + 1) begin
                if (reg_wdata[i] && !active_q[i]) begin
                    if (core_clock_on && used < {1'b0, clock_capacity}) begin
                        active_d[i] = 1'b1;
                        used = used + 9'h001;
                    end else begin
                        // one refused bit is enough to flag the write
                        refused_d = 1'b1;
                    end
                end
            end
        end
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enables_q <= `IPE_ENABLES_RST;
            active_q <= `IPE_ACTIVE_RST;
            underclock_err_q <= 1'b0;
        end else begin
            // enables keep what was written, refused bits included
            if (en_wr) begin
                enables_q <= {4'h0, reg_wdata[`IPE_CHAN_MSB:`IPE_CHAN_LSB]};
            end
            active_q <= active_d;
            // refusal flag pulses for one cycle after the write
            underclock_err_q <= refused_d;
        end
    end

    // read port, status mirrors admitted channels
    // a refused bit reads set in the enables but clear in the status
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `IPE_ENABLES_ADDR: begin
                    reg_rdata_q <= enables_q;
                end
                `IPE_STATUS_ADDR: begin
                    reg_rdata_q <= status_word;
                end
                default: begin
                    // unmapped addresses read zero
                    reg_rdata_q <= 16'h0000;
                end
            endcase
        end
    end

    // mute set at reset, set wins over clear
    // mute gates channel outputs only; capture keeps running
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mute_q <= `IPE_MUTE_RST;
        end else begin
            mute_q <= (mute_q & ~mute_clear) | mute_set;
        end
    end

    // each path has its own clock and capture; no phase is shared
    genvar p;
    generate
        for (p = 0; p < NPATH; p = p + 1) begin : g_path
            wire [23:0] inc;
            // mode select on the first paths only
            if (p < NMODE) begin : g_sel
                assign path_dig[p] = path_input_type_select[p];
            end else begin : g_fix
                assign path_dig[p] = 1'b1;
            end
            assign eff_rate[p*3 +: 3] = noise_cancel_source[p] ? `PDM_RATE_3072K
                                        : pdm_clock_rate_select[p*3 +: 3];
            // rate code to step, family scaling
            assign inc = rate_inc(eff_rate[p*3 +: 3], clock_family_flag);
            // path runs when digital and at least one channel admitted
            assign path_run[p] = path_dig[p] & (active_q[2*p] | active_q[2*p+1]);
            // channel passes data only while admitted and unmuted
            assign left_pass[p] = active_q[2*p+1] & ~mute_q[2*p+1];
            assign right_pass[p] = active_q[2*p] & ~mute_q[2*p];
            assign clk_run[p] = path_run[p] & (inc != 24'h000000);
            // clock out while the path runs on a non-reserved rate code
            pdm_clock_gen i_pdm_clock_gen (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .run(clk_run[p]),
                .inc(inc),
                .pdm_clk_q(pdm_clock_pin[p]),
                .phase_end_q(ph_end[p]),
                .ended_high_q(ph_high[p])
            );
            // capture of the synchronised data pin
            pdm_capture i_pdm_capture (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .run(clk_run[p]),
                .data_pin(pdm_data_pin[p]),
                .phase_end(ph_end[p]),
                .ended_high(ph_high[p]),
                .left_q(cap_left[p]),
                .right_q(cap_right[p]),
                .valid_q(cap_valid[p])
            );
        end
    endgenerate

    // channel gating: on each valid pair, inactive or muted channels deliver zero; a stopped path holds its last bits
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pcm_left_q <= {NPATH{1'b0}};
            pcm_right_q <= {NPATH{1'b0}};
            pcm_valid_q <= {NPATH{1'b0}};
        end else begin
            for (j = 0; j < NPATH; j = j + 1) begin
                pcm_valid_q[j] <= cap_valid[j];
                if (cap_valid[j]) begin
                    pcm_left_q[j] <= cap_left[j] & left_pass[j];
                    pcm_right_q[j] <= cap_right[j] & right_pass[j];
                end
            end
        end
    end

    // slowest running clock sets the sample rate ceiling
    always @* begin
        limit_d = `RATE_LIMIT_192K;
        // limit codes grow with strictness, so the largest one wins
        for (m = 0; m < NPATH; m = m + 1) begin
            if (clk_run[m] && (rate_limit_code(eff_rate[m*3 +: 3]) > limit_d)) begin
                limit_d = rate_limit_code(eff_rate[m*3 +: 3]);
            end
        end
    end

    // ceiling registered; idle or reserved paths do not count
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sample_rate_limit_q <= `RATE_LIMIT_192K;
        end else begin
            sample_rate_limit_q <= limit_d;
        end
    end

endmodule

`default_nettype wire

// file: core/pdm_mic_map.vh
`ifndef PDM_MIC_MAP_VH
`define PDM_MIC_MAP_VH

// register word addresses on the register port
`define IPE_ENABLES_ADDR 16'h0300
`define IPE_STATUS_ADDR 16'h0301

// reset values
`define IPE_ENABLES_RST 16'h0000
`define IPE_STATUS_RST 16'h0000
`define IPE_MUTE_RST 12'hFFF
`define IPE_ACTIVE_RST 12'h000

// channel enable field: bits 11 down to 0, left above right per path
`define IPE_CHAN_MSB 11
`define IPE_CHAN_LSB 0

// pdm clock rate select codes
`define PDM_RATE_384K 3'h2
`define PDM_RATE_768K 3'h3
`define PDM_RATE_1536K 3'h4
`define PDM_RATE_3072K 3'h5
`define PDM_RATE_6144K 3'h6

// sample rate limit codes
`define RATE_LIMIT_192K 2'h0
`define RATE_LIMIT_96K 2'h1
`define RATE_LIMIT_48K 2'h2

// reference clock and microphone clock figures in Hz
`define REF_CLK_HZ 64'd100000000
`define PDM_F384K_HZ 64'd384000
`define PDM_F768K_HZ 64'd768000
`define PDM_F1536K_HZ 64'd1536000
`define PDM_F3072K_HZ 64'd3072000
`define PDM_F6144K_HZ 64'd6144000
// fractional family scale: 5.6448 MHz over 6.144 MHz = 147 / 160
`define PDM_FRAC_NUM 64'd147
`define PDM_FRAC_DEN 64'd160

// phase accumulator: 24 bits, one carry per clock half period
`define PDM_ACC_W 24
`define PDM_ACC_INC(f) (((f) * 64'd33554432) / `REF_CLK_HZ)
`define PDM_ACC_INC_FRAC(f) ((((f) * `PDM_FRAC_NUM) * 64'd33554432) / \
    (`REF_CLK_HZ * `PDM_FRAC_DEN))

`endif

// file: core/pdm_clock_gen.v
`timescale 1ns/100ps
`default_nettype none

module pdm_clock_gen (
    input wire ref_clk,                 // core clock
    input wire resetn,                  // async reset, active low
    input wire run,                     // clock output allowed
    input wire [23:0] inc,              // accumulator step per cycle
    output reg pdm_clk_q,               // microphone clock level
    output reg phase_end_q,             // pulse: a phase just ended
    output reg ended_high_q             // the ended phase was high
);

    reg [23:0] acc_q;
    wire [24:0] sum;

    assign sum = {1'b0, acc_q} + {1'b0, inc};

    // phase accumulator; each carry ends one half period
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= 24'h000000;
            pdm_clk_q <= 1'b0;
            phase_end_q <= 1'b0;
            ended_high_q <= 1'b0;
        end else if (!run) begin
            acc_q <= 24'h000000;
            pdm_clk_q <= 1'b0;
            phase_end_q <= 1'b0;
            ended_high_q <= 1'b0;
        end else begin
            acc_q <= sum[23:0];
            phase_end_q <= sum[24];
            if (sum[24]) begin
                ended_high_q <= pdm_clk_q;
                pdm_clk_q <= ~pdm_clk_q;
            end
        end
    end

endmodule

`default_nettype wire

// file: core/pdm_capture.v
`timescale 1ns/100ps
`default_nettype none

module pdm_capture (
    input wire ref_clk,                 // core clock
    input wire resetn,                  // async reset, active low
    input wire run,                     // path capturing
    input wire data_pin,                // pdm data from the pad
    input wire phase_end,               // pulse: clock phase ended
    input wire ended_high,              // ended phase was high
    output reg left_q,                  // captured left bit
    output reg right_q,                 // captured right bit
    output reg valid_q                  // pulse: new left/right pair
);

    reg sync1_q;
    reg sync2_q;
    reg [1:0] end_dly_q;
    reg [1:0] high_dly_q;
    reg have_left_q;

    // two-stage synchroniser for the pad input
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= data_pin;
            sync2_q <= sync1_q;
        end
    end

    // phase-end strobes delayed to match the synchroniser
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            end_dly_q <= 2'h0;
            high_dly_q <= 2'h0;
        end else begin
            end_dly_q <= {end_dly_q[0], phase_end & run};
            high_dly_q <= {high_dly_q[0], ended_high};
        end
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            left_q <= 1'b0;
            right_q <= 1'b0;
            valid_q <= 1'b0;
            have_left_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (!run) begin
                have_left_q <= 1'b0;
            end else if (end_dly_q[1]) begin
                if (high_dly_q[1]) begin
                    left_q <= sync2_q;
                    have_left_q <= 1'b1;
                end else if (have_left_q) begin
                    // pair closes on the right bit
                    right_q <= sync2_q;
                    valid_q <= 1'b1;
                    have_left_q <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: tb/pdm_mic_pair.sv
`timescale 1ns/100ps
`default_nettype none
module pdm_mic_pair #(
    parameter NPATH = 6
) (
    input wire logic [NPATH-1:0] mic_clk, // clocks from the block
    input wire logic [NPATH-1:0] left_bits, // left mic bit per path
    input wire logic [NPATH-1:0] right_bits, // right mic bit per path
    output wire logic [NPATH-1:0] data // shared data lines
);
    wire [NPATH-1:0] ck_late;
    // mics answer a little after each clock edge
    assign #35 ck_late = mic_clk;
    assign data = (ck_late & left_bits) | (~ck_late & right_bits);
endmodule
`default_nettype wire

// file: tb/pdm_input_path_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pdm_input_path_properties #(
    parameter NPATH = 6
) (
    input wire logic ref_clk, // core clock
    input wire logic resetn, // async reset
    input wire logic [15:0] reg_addr, // address
    input wire logic reg_wr_en, // write strobe
    input wire logic reg_rd_en, // read strobe
    input wire logic [15:0] reg_rdata_q, // read data
    input wire logic clock_family_flag, // clock family
    input wire logic [NPATH*3-1:0] pdm_clock_rate_select, // rates
    input wire logic [NPATH-1:0] noise_cancel_source, // anc source
    input wire logic [11:0] mute_set, // mute pulses
    input wire logic [11:0] mute_clear, // unmute pulses
    input wire logic [NPATH-1:0] pdm_clock_pin, // mic clocks
    input wire logic [NPATH-1:0] pdm_data_pulldown_en, // pull-downs
    input wire logic [11:0] mute_q, // mute state
    input wire logic underclock_err_q // refusal pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // path 0 clock mode helpers
    wire [2:0] r0 = pdm_clock_rate_select[2:0];
    wire c0 = pdm_clock_pin[0];
    wire a0 = noise_cancel_source[0];
    wire rsv0 = (r0 < 3'h2 || r0 == 3'h7) && !a0;
    wire f6 = r0 == 3'h6 && !clock_family_flag && !a0;
    wire f5 = r0 == 3'h5 && clock_family_flag && !a0;
    wire fa = a0 && !clock_family_flag;
    AST_PULL: assert property (pdm_data_pulldown_en == {NPATH{1'b1}})
        else $error("pull-downs off");
    AST_MUTE_RST: assert property (!$past(resetn) |-> mute_q == 12'hFFF)
        else $error("not muted after reset");
    AST_MUTE_SET: assert property (|mute_set |=> (mute_q & $past(mute_set)) == $past(mute_set))
        else $error("mute not set");
    AST_MUTE_CLR: assert property (|mute_clear |=> (mute_q & $past(mute_clear & ~mute_set)) == 0)
        else $error("mute not cleared");
    AST_MUTE_HOLD: assert property (!(|{mute_set, mute_clear}) |=> $stable(mute_q))
        else $error("mute changed by itself");
    AST_ERR_CAUSE: assert property (underclock_err_q |-> $past(reg_wr_en && reg_addr == 16'h0300))
        else $error("refusal without enable write");
    AST_RD_HI: assert property (reg_rd_en |=> reg_rdata_q[15:12] == 4'h0)
        else $error("upper read bits set");
    AST_RD_UNMAP: assert property (reg_rd_en && reg_addr[15:1] != 15'h0180 |=> reg_rdata_q == 0)
        else $error("unmapped read not zero");
    AST_RSV_LOW: assert property (rsv0 && $past(rsv0) |-> !c0)
        else $error("clock runs on reserved code");
    AST_HALF6: assert property ($fell(c0) && f6 && $past(f6, 20) |-> $past(c0, 8) && !$past(c0, 10))
        else $error("wrong half period at top rate");
    AST_HALFF: assert property ($fell(c0) && f5 && $past(f5, 20) |-> $past(c0, 17) && !$past(c0, 19))
        else $error("wrong half period in fractional family");
    AST_HALFA: assert property ($fell(c0) && fa && $past(fa, 20) |-> $past(c0, 16) && !$past(c0, 18))
        else $error("wrong half period for noise-cancel source");
endmodule
bind pdm_input_path pdm_input_path_properties #(.NPATH(NPATH)) i_pdm_input_path_properties (
    .ref_clk, .resetn, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_rdata_q, .clock_family_flag,
    .pdm_clock_rate_select, .noise_cancel_source, .mute_set, .mute_clear, .pdm_clock_pin,
    .pdm_data_pulldown_en, .mute_q, .underclock_err_q
);
`default_nettype wire

// file: tb/test_pdm_input_path.sv
`timescale 1ns/100ps
`default_nettype none
module test_pdm_input_path;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic core_clock_on = 1'b1;
    logic [7:0] clock_capacity = 8'h0C;
    logic clock_family_flag = 1'b0;
    logic [2:0] path_input_type_select = 3'h7;
    logic [17:0] pdm_clock_rate_select = 18'h36DB0;
    logic [5:0] noise_cancel_source = 6'h00;
    logic [11:0] mute_set = 12'h000;
    logic [11:0] mute_clear = 12'h000;
    wire [15:0] reg_rdata_q;
    wire [11:0] mute_q;
    wire [5:0] pdm_data_pin, pdm_clock_pin, pdm_data_pulldown_en;
    wire [5:0] pcm_left_q, pcm_right_q, pcm_valid_q;
    wire underclock_err_q;
    wire [1:0] sample_rate_limit_q;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int k;
    logic err_seen;
    logic [5:0] tog, vseen;
    localparam logic [5:0] LB = 6'h2B;
    localparam logic [5:0] RB = 6'h14;
    pdm_input_path i_pdm_input_path (
        .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en, .reg_rdata_q,
        .core_clock_on, .clock_capacity, .clock_family_flag, .path_input_type_select,
        .pdm_clock_rate_select, .noise_cancel_source, .mute_set, .mute_clear, .pdm_data_pin,
        .pdm_clock_pin, .pdm_data_pulldown_en, .pcm_left_q, .pcm_right_q, .pcm_valid_q,
        .mute_q, .underclock_err_q, .sample_rate_limit_q
    );
    // all six mic pin pairs wired, paths 3-5 included
    pdm_mic_pair i_pdm_mic_pair (
        .mic_clk(pdm_clock_pin), .left_bits(LB), .right_bits(RB), .data(pdm_data_pin)
    );
    // 100 MHz core clock
    always #5 ref_clk = ~ref_clk;
    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            give_verdict();
        end
    end
    // compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // register write, refusal flag sampled after the taking edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1 reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1 reg_wr_en = 1'b0;
        err_seen = underclock_err_q;
    endtask
    // register read, data one cycle later
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        #1 reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1 reg_rd_en = 1'b0;
        chk("rdata", reg_rdata_q, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // collect clock toggles and valid pulses per path
    task automatic watch(input int n);
        logic [5:0] last;
        tog = 6'h00;
        vseen = 6'h00;
        last = pdm_clock_pin;
        repeat (n) begin
            @(posedge ref_clk);
            #1 tog = tog | (pdm_clock_pin ^ last);
            vseen = vseen | pcm_valid_q;
            last = pdm_clock_pin;
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1'b1;
        chk("mute", mute_q, 12'hFFF);
        chk("limit", sample_rate_limit_q, 2'h0);
        rd(16'h0300, 16'h0000);
        rd(16'h0301, 16'h0000);
        rd(16'h0302, 16'h0000);
        // capacity runs out, active channel kept
        clock_capacity = 8'h01;
        wr(16'h0300, 16'h0003);
        chk("err", err_seen, 1'b1);
        rd(16'h0300, 16'h0003);
        rd(16'h0301, 16'h0001);
        wr(16'h0300, 16'h0001);
        clock_capacity = 8'h02;
        wr(16'h0300, 16'h000D);
        chk("err", err_seen, 1'b1);
        rd(16'h0301, 16'h0005);
        wr(16'h0301, 16'h0FFF);
        rd(16'h0301, 16'h0005);
        wr(16'h0300, 16'h0000);
        chk("err", err_seen, 1'b0);
        // system clock off refuses all
        core_clock_on = 1'b0;
        wr(16'h0300, 16'h0003);
        chk("err", err_seen, 1'b1);
        rd(16'h0301, 16'h0000);
        // system clock back on before enabling
        core_clock_on = 1'b1;
        clock_capacity = 8'h0C;
        wr(16'h0300, 16'h0000);
        wr(16'h0300, 16'h0FFF);
        rd(16'h0301, 16'h0FFF);
        // unmute, capture, then mute one channel
        // unmute as the last enable step
        mute_clear = 12'hFFF;
        idle(1);
        mute_clear = 12'h000;
        chk("mute", mute_q, 12'h000);
        idle(100);
        chk("left", pcm_left_q, LB & 6'h3E);
        chk("right", pcm_right_q, RB & 6'h3E);
        mute_set = 12'h008;
        idle(1);
        mute_set = 12'h000;
        idle(60);
        chk("left", pcm_left_q, LB & 6'h3C);
        // limit follows path 0 clock code
        for (k = 2; k < 7; k++) begin
            pdm_clock_rate_select[2:0] = k[2:0];
            idle(200);
            chk("limit", sample_rate_limit_q, k == 2 ? 2'h2 : k == 3 ? 2'h1 : 2'h0);
        end
        // fractional family, then noise-cancel override
        pdm_clock_rate_select[2:0] = 3'h5;
        clock_family_flag = 1'b1;
        idle(200);
        clock_family_flag = 1'b0;
        noise_cancel_source = 6'h01;
        // slowest code would cap at 48k unless overridden
        pdm_clock_rate_select[2:0] = 3'h2;
        idle(200);
        chk("limit", sample_rate_limit_q, 2'h0);
        // reserved code stops path 0
        noise_cancel_source = 6'h00;
        pdm_clock_rate_select[2:0] = 3'h0;
        idle(4);
        watch(100);
        chk("clk pins", tog, 6'h3E);
        chk("valid", vseen, 6'h3E);
        // analogue mode on path 1 drives no clock
        path_input_type_select = 3'h5;
        idle(4);
        watch(100);
        chk("clk pins", tog, 6'h3C);
        chk("valid", vseen, 6'h3C);
        mute_set = 12'hFFF;
        idle(1);
        mute_set = 12'h000;
        chk("mute", mute_q, 12'hFFF);
        wr(16'h0300, 16'h0000);
        idle(4);
        chk("clk pins", pdm_clock_pin, 6'h00);
        chk("pulldown", pdm_data_pulldown_en, 6'h3F);
        give_verdict();
    end
endmodule
`default_nettype wire
